/* hdl/hps_pkg.sv */
/*
 * Constants and types shared by the host interface pin select block.
 * Assumes a register engine elsewhere passes configuration writes in
 * as a strobe with address and data on the system clock.
 */
// Behaviour
// - device answers host only as slave
// - select pin low SPI, high I2C
// - SPI and I2C share the same pins
// - SPI defaults to four wire arrangement
// - configuration write switches SPI to three wire
// - SDI is input, bidirectional, or SDA
// - three wire enable needs power control first
// - I2C address upper bits fixed 00100
`default_nettype none

package hps_pkg;

    typedef enum logic [1:0] {
        HPS_MODE_SPI4 = 2'b00,
        HPS_MODE_SPI3 = 2'b01,
        HPS_MODE_I2C = 2'b10
    } hps_mode_t;

    localparam int HPS_ADDR_W = 7;
    localparam int HPS_DATA_W = 8;
    localparam int HPS_I2C_ADDR_W = 7;

    // register holding the three wire enable bit
    localparam logic [6:0] HPS_THREE_WIRE_ADDR = 7'h4B;
    localparam int HPS_THREE_WIRE_BIT = 0;
    localparam logic HPS_THREE_WIRE_RESET = 1'b0;

    // select pin levels
    localparam logic HPS_SEL_SPI = 1'b0;
    localparam logic HPS_SEL_I2C = 1'b1;

    // fixed upper slave address bits and pin positions in the address
    localparam logic [4:0] HPS_I2C_ADDR_UPPER = 5'h04;
    localparam int HPS_I2C_ADDR_CSB_BIT = 1;
    localparam int HPS_I2C_ADDR_SDO_BIT = 0;

    localparam hps_mode_t HPS_MODE_RESET = HPS_MODE_SPI4;

    // pins sampled by the three stage synchroniser
    localparam int HPS_SYNC_W = 3;
    localparam logic [2:0] HPS_SYNC_RESET = 3'h2;
    localparam int HPS_SYNC_SEL = 0;
    localparam int HPS_SYNC_CSB = 1;
    localparam int HPS_SYNC_SDO = 2;

endpackage

`default_nettype wire

/* hdl/hps_sync3.sv */
/*
 * Three stage synchroniser for slow pin levels.
 * Assumes inputs change far slower than the sampling clock.
 */
`default_nettype none

module hps_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pin side
    input wire logic [WIDTH-1:0] pinLevel,
    // synchronised side
    output logic [WIDTH-1:0] stableLevel
);

    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;
    logic [WIDTH-1:0] stage3Reg;
    logic [WIDTH-1:0] stableReg;
    logic [WIDTH-1:0] stableNext;

    // a bit moves only when stages two and three agree; stage one feeds
    // nothing but stage two
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign stableNext[i] = (stage2Reg[i] == stage3Reg[i]) ?
                stage3Reg[i] : stableReg[i];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1Reg <= RESET_VALUE;
            stage2Reg <= RESET_VALUE;
            stage3Reg <= RESET_VALUE;
            stableReg <= RESET_VALUE;
        end else begin
            stage1Reg <= pinLevel;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            stableReg <= stableNext;
        end
    end

    assign stableLevel = stableReg;

endmodule // hps_sync3

`default_nettype wire

/* hdl/hps_pin_select.sv */
/*
 * Pin role selection for the shared host serial interface of a sensor
 * acting as bus slave: protocol choice, SPI four or three wire, and the
 * I2C address bits taken from the otherwise unused pins.
 * Assumes the protocol engines run on the serial clock and hand over
 * their transmit bit and drive request in that domain; configuration
 * writes arrive on the system clock.
 */
`default_nettype none

module hps_pin_select
    import hps_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pins
    input wire logic protocolSelectPin,
    input wire logic chipSelectNPin,
    input wire logic serialClockPin,
    input wire logic sdoPinIn,
    output logic sdoPinOut,
    output logic sdoPinOe,
    input wire logic sdiPinIn,
    output logic sdiPinOut,
    output logic sdiPinOe,
    // configuration from the register engine
    input wire logic powerControlBit,
    input wire logic cfgWriteStrobe,
    input wire logic [hps_pkg::HPS_ADDR_W-1:0] cfgWriteAddr,
    input wire logic [hps_pkg::HPS_DATA_W-1:0] cfgWriteData,
    // state towards the protocol engines
    output hps_pkg::hps_mode_t activeMode,
    output logic threeWireEnable,
    output logic spiChipEnable,
    output logic [hps_pkg::HPS_I2C_ADDR_W-1:0] i2cSlaveAddress,
    // link side, serial clock domain
    input wire logic linkTxBit,
    input wire logic linkTxDrive,
    output logic linkRxBit
);

    import hps_pkg::*;

    logic [HPS_SYNC_W-1:0] pinRaw;
    logic [HPS_SYNC_W-1:0] pinStable;
    logic selStable;
    logic csbStable;
    logic sdoStable;

    hps_mode_t modeReg;
    hps_mode_t modeNext;
    logic threeWireReg;
    logic threeWireNext;
    logic [HPS_I2C_ADDR_W-1:0] i2cAddrReg;
    logic [HPS_I2C_ADDR_W-1:0] i2cAddrNext;
    logic chipEnableReg;
    logic chipEnableNext;

    logic spiFrameOpen;
    logic threeWireWrite;
    logic isI2c;
    logic isSpi3;
    logic isSpi4;

    logic rxBitReg;
    logic txBitReg;

    function automatic logic is_mode(input hps_mode_t m, input hps_mode_t t);
        return m == t;
    endfunction

    // slow pin levels into the system domain
    assign pinRaw[HPS_SYNC_SEL] = protocolSelectPin;
    assign pinRaw[HPS_SYNC_CSB] = chipSelectNPin;
    assign pinRaw[HPS_SYNC_SDO] = sdoPinIn;

    hps_sync3 #(
        .WIDTH(HPS_SYNC_W),
        .RESET_VALUE(HPS_SYNC_RESET)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pinLevel(pinRaw),
        .stableLevel(pinStable)
    );

    assign selStable = pinStable[HPS_SYNC_SEL];
    assign csbStable = pinStable[HPS_SYNC_CSB];
    assign sdoStable = pinStable[HPS_SYNC_SDO];

    assign isI2c = is_mode(modeReg, HPS_MODE_I2C);
    assign isSpi3 = is_mode(modeReg, HPS_MODE_SPI3);
    assign isSpi4 = is_mode(modeReg, HPS_MODE_SPI4);

    // the enable is only taken once power control is set
    assign threeWireWrite = cfgWriteStrobe && powerControlBit &&
        (cfgWriteAddr == HPS_THREE_WIRE_ADDR);
    assign threeWireNext = threeWireWrite ?
        cfgWriteData[HPS_THREE_WIRE_BIT] : threeWireReg;

    // roles are frozen while an SPI frame is open, so a late select change
    // cannot swap pin roles under a running transfer
    assign spiFrameOpen = !isI2c && !csbStable;

    always_comb begin
        modeNext = modeReg;
        if (!spiFrameOpen) begin
            case (selStable)
                HPS_SEL_I2C: modeNext = HPS_MODE_I2C;
                HPS_SEL_SPI: begin
                    modeNext = threeWireNext ? HPS_MODE_SPI3
                        : HPS_MODE_SPI4;
                end
                default: modeNext = HPS_MODE_RESET;
            endcase
        end
    end

    // address bits follow the pin levels in I2C, hold otherwise
    assign i2cAddrNext = isI2c ?
        {HPS_I2C_ADDR_UPPER, csbStable, sdoStable} : i2cAddrReg;
    // chip select acts as enable only in SPI
    assign chipEnableNext = !is_mode(modeNext, HPS_MODE_I2C) &&
        !csbStable;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= HPS_MODE_RESET;
            threeWireReg <= HPS_THREE_WIRE_RESET;
            i2cAddrReg <= {HPS_I2C_ADDR_UPPER, 2'h0};
            chipEnableReg <= 1'b0;
        end else begin
            modeReg <= modeNext;
            threeWireReg <= threeWireNext;
            i2cAddrReg <= i2cAddrNext;
            chipEnableReg <= chipEnableNext;
        end
    end

    // link domain: the serial clock pin is the clock in both protocols;
    // it may stand still between frames, so these flops hold only data.
    // reset acts asynchronously here as no edge is guaranteed after it
    always_ff @(posedge serialClockPin or negedge reset_n) begin
        if (!reset_n) begin
            rxBitReg <= 1'b0;
        end else begin
            rxBitReg <= sdiPinIn;
        end
    end

    // data is launched on the falling edge for capture on the rising one
    always_ff @(negedge serialClockPin or negedge reset_n) begin
        if (!reset_n) begin
            txBitReg <= 1'b0;
        end else begin
            txBitReg <= linkTxBit;
        end
    end

    // pin roles; mode is quasi static while a frame runs, so mixing it
    // with the link-side drive request here is glitch safe in practice
    assign sdoPinOut = txBitReg;
    assign sdoPinOe = isSpi4 && chipEnableReg && linkTxDrive;
    // I2C is open drain: only a low is ever driven on SDA
    assign sdiPinOut = isI2c ? 1'b0 : txBitReg;
    assign sdiPinOe = linkTxDrive && ((isSpi3 && chipEnableReg) ||
        (isI2c && !txBitReg));

    assign linkRxBit = rxBitReg;
    assign activeMode = modeReg;
    assign threeWireEnable = threeWireReg;
    assign spiChipEnable = chipEnableReg;
    assign i2cSlaveAddress = i2cAddrReg;

    a_sel_low_spi: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (selStable == HPS_SEL_SPI && !spiFrameOpen) |=> !isI2c)
        else $error("select low did not give SPI");

    a_sel_high_i2c: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (selStable == HPS_SEL_I2C && !spiFrameOpen) |=> isI2c)
        else $error("select high did not give I2C");

    a_default_four_wire: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!threeWireNext && selStable == HPS_SEL_SPI && !spiFrameOpen)
        |=> isSpi4)
        else $error("SPI left four wire without enable");

    a_three_wire_set: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (threeWireWrite && cfgWriteData[HPS_THREE_WIRE_BIT] &&
        selStable == HPS_SEL_SPI && !spiFrameOpen)
        |=> threeWireReg && isSpi3)
        else $error("three wire write not taken");

    a_three_wire_gate: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfgWriteStrobe && !powerControlBit) |=> $stable(threeWireReg))
        else $error("three wire changed without power control");

    a_i2c_address: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        isI2c |=> i2cAddrReg == {HPS_I2C_ADDR_UPPER,
        $past(csbStable), $past(sdoStable)})
        else $error("I2C address does not follow pins");

    a_sdo_role: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        sdoPinOe |-> isSpi4 && chipEnableReg)
        else $error("SDO driven outside SPI four wire frame");

    a_sdi_role: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        sdiPinOe |-> (isSpi3 || (isI2c && !sdiPinOut)))
        else $error("SDI driven in wrong role");

    a_chip_enable: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        spiChipEnable |-> !isI2c && !$past(csbStable))
        else $error("chip enable outside SPI or with select high");

    a_frame_freeze: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        spiFrameOpen |=> modeReg == $past(modeReg))
        else $error("pin roles changed during SPI frame");

endmodule // hps_pin_select

`default_nettype wire

/* bench/hps_host_model.sv */
/*
 * Host master model for the shared serial pins: protocol select,
 * chip select, serial clock bursts and the host's own data drive.
 * Assumes the bench resolves the shared data lines from all enables.
 */
`default_nettype none

module hps_host_model (
    // pins driven by the host
    output logic protocolSelectPin,
    output logic chipSelectNPin,
    output logic serialClockPin,
    output logic hostSdi,
    output logic hostSdiOe,
    // strap level on the data-out pin
    output logic sdoStrap
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        protocolSelectPin = 1'b0;
        chipSelectNPin = 1'b1;
        serialClockPin = 1'b1;
        hostSdi = 1'b0;
        hostSdiOe = 1'b0;
        sdoStrap = 1'b0;
    end

    // select pin only moves between frames, never mid-transfer
    task automatic setPins(input logic sel, input logic chip_select_n_pin,
        input logic strap, input logic oe);
        protocolSelectPin = sel;
        chipSelectNPin = chip_select_n_pin;
        sdoStrap = strap;
        hostSdiOe = oe;
    endtask

    // clock idles high and stands still outside frames
    task automatic clockBit(input logic b);
        serialClockPin = 1'b0;
        hostSdi = b;
        #3;
        serialClockPin = 1'b1;
        #3;
    endtask
endmodule // hps_host_model

`default_nettype wire

/* bench/host_interface_pin_select_tb.sv */
/*
 * Self-checking bench for the pin select block with a host model.
 * Assumes the data-out pin floats to its strap and the shared data
 * pin has a pull-up when nobody drives it.
 */
`default_nettype none

module host_interface_pin_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hps_pkg::*;

    logic clk_sys = 1'b0;
    logic reset_n, powerControlBit, cfgWriteStrobe, linkTxBit;
    logic linkTxDrive, sdoPinOut, sdoPinOe, sdiPinOut, sdiPinOe;
    logic linkRxBit, threeWireEnable, spiChipEnable;
    logic [6:0] cfgWriteAddr;
    logic [7:0] cfgWriteData;
    logic [6:0] i2cSlaveAddress;
    hps_mode_t activeMode;
    wire logic sel, csbN, sck, hostSdi, hostSdiOe, sdoStrap;
    wire logic sdiLine = sdiPinOe ? sdiPinOut : hostSdiOe ? hostSdi : 1'b1;
    wire logic sdoLine = sdoPinOe ? sdoPinOut : sdoStrap;
    int n_errors = 0;
    int check_count = 0;

    always #50 clk_sys = ~clk_sys;

    hps_host_model u_host (.protocolSelectPin(sel), .chipSelectNPin(csbN),
        .serialClockPin(sck), .hostSdi(hostSdi), .hostSdiOe(hostSdiOe),
        .sdoStrap(sdoStrap));

    hps_pin_select u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .protocolSelectPin(sel), .chipSelectNPin(csbN),
        .serialClockPin(sck), .sdoPinIn(sdoLine), .sdoPinOut(sdoPinOut),
        .sdoPinOe(sdoPinOe), .sdiPinIn(sdiLine), .sdiPinOut(sdiPinOut),
        .sdiPinOe(sdiPinOe), .powerControlBit(powerControlBit),
        .cfgWriteStrobe(cfgWriteStrobe), .cfgWriteAddr(cfgWriteAddr),
        .cfgWriteData(cfgWriteData), .activeMode(activeMode),
        .threeWireEnable(threeWireEnable), .spiChipEnable(spiChipEnable),
        .i2cSlaveAddress(i2cSlaveAddress), .linkTxBit(linkTxBit),
        .linkTxDrive(linkTxDrive), .linkRxBit(linkRxBit));

    task automatic chkBit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chkVec(input string n, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // synchroniser plus mode register need five edges; allow eight
    task automatic pins(input logic s, input logic c, input logic st,
        input logic oe);
        @(negedge clk_sys);
        u_host.setPins(s, c, st, oe);
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic cfgWrite(input logic p, input logic [6:0] a,
        input logic [7:0] d);
        @(negedge clk_sys);
        powerControlBit = p;
        cfgWriteStrobe = 1'b1;
        cfgWriteAddr = a;
        cfgWriteData = d;
        @(negedge clk_sys);
        cfgWriteStrobe = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic t_reset;
        chkVec("mode", 8'(HPS_MODE_SPI4), 8'(activeMode));
        chkBit("3w", 1'b0, threeWireEnable);
        chkVec("addr", 8'h10, 8'(i2cSlaveAddress));
        chkBit("sdoOe", 1'b0, sdoPinOe);
    endtask

    // enter I2C with chip select high first: a select change while chip
    // select is low looks like an open SPI frame and is held off
    task automatic t_i2c;
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        chkVec("mode", 8'(HPS_MODE_I2C), 8'(activeMode));
        chkVec("addr", 8'h12, 8'(i2cSlaveAddress));
        for (int i = 0; i < 4; i++) begin
            pins(1'b1, i[1], i[0], 1'b0);
            chkVec("mode", 8'(HPS_MODE_I2C), 8'(activeMode));
            chkVec("addr", 8'h10 + 8'(i), 8'(i2cSlaveAddress));
            chkBit("ce", 1'b0, spiChipEnable);
        end
        linkTxDrive = 1'b1;
        for (int b = 0; b < 2; b++) begin
            linkTxBit = b[0];
            u_host.clockBit(1'b1);
            chkBit("sdaOe", ~b[0], sdiPinOe);
            chkBit("sda", b[0], sdiLine);
            chkBit("sdoOe", 1'b0, sdoPinOe);
        end
        linkTxDrive = 1'b0;
    endtask

    task automatic t_cfg;
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        chkVec("mode", 8'(HPS_MODE_SPI4), 8'(activeMode));
        cfgWrite(1'b0, 7'h4B, 8'h01);
        chkBit("3w", 1'b0, threeWireEnable);
        cfgWrite(1'b1, 7'h4A, 8'h01);
        chkBit("3w", 1'b0, threeWireEnable);
        cfgWrite(1'b1, 7'h4B, 8'hFE);
        chkBit("3w", 1'b0, threeWireEnable);
        cfgWrite(1'b1, 7'h4B, 8'h01);
        chkBit("3w", 1'b1, threeWireEnable);
        chkVec("mode", 8'(HPS_MODE_SPI3), 8'(activeMode));
    endtask

    // one frame of eight bits each way; 3-wire loops back on SDI
    task automatic t_spi(input logic three);
        logic [7:0] tx;
        logic [7:0] rx;
        tx = 8'hA5;
        rx = 8'h3C;
        cfgWrite(1'b1, 7'h4B, {7'h00, three});
        chkBit("3w", three, threeWireEnable);
        pins(1'b0, 1'b0, 1'b0, ~three);
        chkBit("ce", 1'b1, spiChipEnable);
        linkTxDrive = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            linkTxBit = tx[i];
            u_host.clockBit(rx[i]);
            chkBit("sdoOe", ~three, sdoPinOe);
            chkBit("sdiOe", three, sdiPinOe);
            chkBit("out", tx[i], three ? sdiPinOut : sdoPinOut);
            chkBit("rx", three ? tx[i] : rx[i], linkRxBit);
        end
        linkTxDrive = 1'b0;
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        chkBit("ce", 1'b0, spiChipEnable);
        chkBit("sdoOe", 1'b0, sdoPinOe);
    endtask

    initial begin
        reset_n = 1'b0;
        powerControlBit = 1'b0;
        cfgWriteStrobe = 1'b0;
        cfgWriteAddr = '0;
        cfgWriteData = '0;
        linkTxBit = 1'b0;
        linkTxDrive = 1'b0;
        repeat (20) @(negedge clk_sys);
        t_reset;
        reset_n = 1'b1;
        t_i2c;
        t_cfg;
        t_spi(1'b0);
        t_spi(1'b1);
        finish_test;
    end

    // whole run is well under a thousand system cycles
    initial begin
        #200000;
        n_errors++;
        finish_test;
    end
endmodule // host_interface_pin_select_tb

`default_nettype wire
